// ==== idsf_status_flags.sv ====
// Interface error flags and device condition flags registers
//
// Function
// - Bit 7 of interface flags sets on early transaction; write one clears.
// - Bit 4 sets on wrong serial clock count; plain read/write bit.
// - Bit 3 sets on checksum mismatch only when enabled; write one clears.
// - Bit 2 sets on write to read-only register; write one clears.
// - Bit 1 sets on partial multibyte access when strict; write one clears.
// - Bit 0 sets on access to unimplemented address; write one clears.
// - Device bit 6 follows common-input clamp live, unlatched.
// - Device bit 5 reads one after reset, clears when read.
// - Device bit 3 is OR of all sixteen channel alert bits.
// - Device bit 2 is OR of all interface flag bits.
// - Device bit 1 latches per-channel clamps, not the common clamp; read clears only if none active.
// - Checksum enabled only when fields hold 0x1 and 0x2.
`timescale 1ns/1ps
`include "idsf_map.svh"

module idsf_status_flags #(
  parameter int N_CH = 8
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire idsf_pkg::idsf_acc_s  i_acc,
  input  wire idsf_pkg::idsf_err_s  i_err,
  input  wire logic [1:0]           i_cks_en,
  input  wire logic [1:0]           i_cks_en_n,
  input  wire logic                 i_whole_register_access_select,
  input  wire logic                 i_com_clamp,
  input  wire logic [N_CH-1:0]      i_upper_limit_alert_bit,
  input  wire logic [N_CH-1:0]      i_lower_limit_alert_bit,
  input  wire logic [N_CH-1:0]      i_per_channel_clamp_bit,
  output logic [7:0]                o_rdata,
  output logic [7:0]                o_interface_error_flags,
  output logic [7:0]                o_device_condition_flags
);

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // The clamp comparators are analog and asynchronous to this clock
  logic [1:0]      com_sync_q;
  logic [1:0]      com_sync_d;
  logic [N_CH-1:0] clamp_s1_q;
  logic [N_CH-1:0] clamp_s2_q;

  always_comb begin
    com_sync_d = {com_sync_q[0], i_com_clamp};
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      com_sync_q <= 2'h0;
      clamp_s1_q <= '0;
      clamp_s2_q <= '0;
    end else if (i_ce) begin
      com_sync_q <= com_sync_d;
      clamp_s1_q <= i_per_channel_clamp_bit;
      clamp_s2_q <= clamp_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Interface error flags
  // ----------------------------------------------------------------
  logic [7:0] iferr_q;
  logic [7:0] iferr_d;
  logic       cks_on;
  logic       wr_iferr;
  logic       rd_devcond;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  assign cks_on = (i_cks_en == `IDSF_CKS_EN_ON) &&
                  (i_cks_en_n == `IDSF_CKS_EN_N_ON);
  assign wr_iferr   = i_acc.wr && (i_acc.addr == `IDSF_IFERR_ADDR);
  assign rd_devcond = i_acc.rd && (i_acc.addr == `IDSF_DEVCOND_ADDR);

  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`IDSF_BIT_NOT_READY] = i_err.not_ready;
    set_v[`IDSF_BIT_CLK_COUNT] = i_err.clk_count;
    set_v[`IDSF_BIT_CHECKSUM]  = i_err.checksum && cks_on;
    set_v[`IDSF_BIT_BAD_WRITE] = i_err.bad_write;
    // Strict mode gate; host is expected to honour whole-register access
    set_v[`IDSF_BIT_MULTIBYTE] = i_err.multibyte &&
                                 i_whole_register_access_select;
    set_v[`IDSF_BIT_BAD_ADDR]  = i_err.bad_addr;
    if (wr_iferr) begin
      clr_v = i_acc.wdata & `IDSF_IFERR_WMASK;
      // Clock count bit is plain R/W: writing zero clears, one sets
      clr_v[`IDSF_BIT_CLK_COUNT] = ~i_acc.wdata[`IDSF_BIT_CLK_COUNT];
      set_v[`IDSF_BIT_CLK_COUNT] = set_v[`IDSF_BIT_CLK_COUNT] |
                                   i_acc.wdata[`IDSF_BIT_CLK_COUNT];
    end
    // A new event in the clearing cycle wins over the clear
    iferr_d = ((iferr_q & ~clr_v) | set_v) & `IDSF_IFERR_WMASK;
  end

  // ----------------------------------------------------------------
  // Device condition flags
  // ----------------------------------------------------------------
  logic       reset_seen_q;
  logic       reset_seen_d;
  logic       clamp_sum_q;
  logic       clamp_sum_d;
  logic [7:0] devcond;
  logic       any_clamp;

  assign any_clamp = |clamp_s2_q;

  always_comb begin
    reset_seen_d = reset_seen_q && !rd_devcond;
    // Clear on read only when no channel clamp is still active
    clamp_sum_d = any_clamp || (clamp_sum_q && !rd_devcond);
  end

  always_comb begin
    devcond = 8'h00;
    devcond[`IDSF_BIT_COM_CLAMP]  = com_sync_q[1];
    devcond[`IDSF_BIT_RESET_SEEN] = reset_seen_q;
    devcond[`IDSF_BIT_ALERT_SUM]  = |{i_upper_limit_alert_bit,
                                      i_lower_limit_alert_bit};
    devcond[`IDSF_BIT_IFERR_SUM]  = |iferr_q;
    devcond[`IDSF_BIT_CLAMP_SUM]  = clamp_sum_q;
  end

  // ----------------------------------------------------------------
  // Read data and registers
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (i_acc.rd && i_acc.addr == `IDSF_IFERR_ADDR) begin
      rdata_d = iferr_q;
    end else if (rd_devcond) begin
      rdata_d = devcond;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      iferr_q                  <= `IDSF_IFERR_RESET;
      reset_seen_q             <= 1'b1;
      clamp_sum_q              <= 1'b0;
      o_rdata                  <= 8'h00;
      o_interface_error_flags  <= `IDSF_IFERR_RESET;
      o_device_condition_flags <= `IDSF_DEVCOND_RESET;
    end else if (i_ce) begin
      iferr_q                  <= iferr_d;
      reset_seen_q             <= reset_seen_d;
      clamp_sum_q              <= clamp_sum_d;
      o_rdata                  <= rdata_d;
      o_interface_error_flags  <= iferr_q;
      o_device_condition_flags <= devcond;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_not_ready_set: assert property (i_ce && i_err.not_ready
    |=> iferr_q[7])
    else $error("not-ready flag not set");
  chk_clk_count_set: assert property (i_ce && i_err.clk_count
    |=> iferr_q[4])
    else $error("clock count flag not set");
  chk_checksum_gate: assert property (i_ce && i_err.checksum && cks_on
    |=> iferr_q[3])
    else $error("checksum flag not set");
  chk_checksum_off: assert property (i_ce && !cks_on && !$past(iferr_q[3])
    ##0 !iferr_q[3] |=> !iferr_q[3] || $past(cks_on))
    else $error("checksum flag set while disabled");
  chk_bad_write_set: assert property (i_ce && i_err.bad_write
    |=> iferr_q[2])
    else $error("invalid write flag not set");
  chk_multibyte_set: assert property (i_ce && i_err.multibyte &&
    i_whole_register_access_select |=> iferr_q[1])
    else $error("multibyte flag not set");
  chk_bad_addr_set: assert property (i_ce && i_err.bad_addr
    |=> iferr_q[0])
    else $error("invalid address flag not set");
  chk_w1c_clear: assert property (i_ce && wr_iferr && i_acc.wdata[0] &&
    !i_err.bad_addr |=> !iferr_q[0])
    else $error("write one did not clear address flag");
  chk_reserved_zero: assert property (iferr_q[6:5] == 2'h0 &&
    devcond[7] == 1'b0 && devcond[4] == 1'b0 && devcond[0] == 1'b0)
    else $error("reserved bit not zero");
  chk_reset_clear: assert property (i_ce && rd_devcond |=> !reset_seen_q)
    else $error("reset flag not cleared by read");
  chk_clamp_hold: assert property (i_ce && any_clamp |=> clamp_sum_q)
    else $error("clamp summary not latched");
  chk_iferr_sum: assert property (devcond[2] == (iferr_q != 8'h00))
    else $error("interface error summary wrong");
  chk_com_follow: assert property (i_ce && com_sync_q[1]
    |=> o_device_condition_flags[6])
    else $error("common clamp bit not shown");

  cov_w1c: cover property (i_ce && wr_iferr && iferr_q != 8'h00);
  cov_reset_read: cover property (i_ce && rd_devcond && reset_seen_q);
  cov_clamp_keep: cover property (i_ce && rd_devcond && any_clamp);

endmodule : idsf_status_flags

// ==== idsf_map.svh ====
// Register offsets, bit positions and reset values for the status flag bank
`ifndef IDSF_MAP_SVH
`define IDSF_MAP_SVH
`define IDSF_IFERR_ADDR      15'h0011
`define IDSF_DEVCOND_ADDR    15'h0014
`define IDSF_IFERR_RESET     8'h00
`define IDSF_DEVCOND_RESET   8'h20
`define IDSF_IFERR_WMASK     8'h9F
`define IDSF_BIT_NOT_READY   7
`define IDSF_BIT_CLK_COUNT   4
`define IDSF_BIT_CHECKSUM    3
`define IDSF_BIT_BAD_WRITE   2
`define IDSF_BIT_MULTIBYTE   1
`define IDSF_BIT_BAD_ADDR    0
`define IDSF_BIT_COM_CLAMP   6
`define IDSF_BIT_RESET_SEEN  5
`define IDSF_BIT_ALERT_SUM   3
`define IDSF_BIT_IFERR_SUM   2
`define IDSF_BIT_CLAMP_SUM   1
`define IDSF_CKS_EN_ON       2'h1
`define IDSF_CKS_EN_N_ON     2'h2
`endif

// ==== idsf_pkg.sv ====
// Types shared by the status flag bank
package idsf_pkg;
  // Error events raised by the serial framing logic, one-cycle pulses
  typedef struct packed {
    logic not_ready;
    logic clk_count;
    logic checksum;
    logic bad_write;
    logic multibyte;
    logic bad_addr;
  } idsf_err_s;

  // Register access from the serial framing logic
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } idsf_acc_s;
endpackage : idsf_pkg

// ==== idsf_host_model.sv ====
// Host-side model issuing single-byte register accesses
`timescale 1ns/1ps
module idsf_host_model (
  input  wire logic           i_ref_clk,
  output idsf_pkg::idsf_acc_s o_acc
);
  initial o_acc = '0;
  // One strobe cycle; a released bus shows inverted address and data
  task automatic xfer(input logic w, input logic [14:0] a,
                      input logic [7:0] d);
    @(posedge i_ref_clk);
    o_acc <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_ref_clk);
    o_acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : idsf_host_model

// ==== tb_idsf_status_flags.sv ====
// Self-checking bench for the status flag registers
`timescale 1ns/1ps
module tb_idsf_status_flags;
  logic                clk = 0, rst = 1, com = 0, strict = 1, pend = 0;
  logic                ce = 1;
  logic [7:0]          ifl, dfl;
  logic [1:0]          en = 2'h1, en_n = 2'h2;
  logic [7:0]          up = '0, lo = '0, clmp = '0, rdata, e, m;
  logic [31:0]         seed = 32'h506F;
  idsf_pkg::idsf_err_s err = '0;
  idsf_pkg::idsf_acc_s acc;
  logic [7:0]          q[$];
  int                  n_mismatch = 0, compares = 0;

  initial forever #12.5 clk = ~clk;

  idsf_host_model i_idsf_host_model (.i_ref_clk(clk), .o_acc(acc));
  idsf_status_flags i_idsf_status_flags (
    .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_acc(acc), .i_err(err),
    .i_cks_en(en), .i_cks_en_n(en_n),
    .i_whole_register_access_select(strict), .i_com_clamp(com),
    .i_upper_limit_alert_bit(up), .i_lower_limit_alert_bit(lo),
    .i_per_channel_clamp_bit(clmp), .o_rdata(rdata),
    .o_interface_error_flags(ifl), .o_device_condition_flags(dfl));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic rd(input logic [14:0] a, input logic [7:0] x);
    q.push_back(x);
    i_idsf_host_model.xfer(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    i_idsf_host_model.xfer(1'b1, a, d);
  endtask : wr

  task automatic pulse(input idsf_pkg::idsf_err_s p);
    @(posedge clk);
    err <= p;
    @(posedge clk);
    err <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // Flag copies are looked at mid-cycle, well away from their launch edge
  task automatic chk_flags(input logic [7:0] xi, input logic [7:0] xd);
    @(negedge clk);
    compares += 2;
    if (ifl !== xi) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, ifl, xi);
    end
    if (dfl !== xd) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, dfl, xd);
    end
  endtask : chk_flags

  task automatic end_of_test();
    if (q.size() != 0) n_mismatch++;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Read data stands for the cycle after the read strobe
  always @(posedge clk) begin
    if (pend) begin
      e = (q.size() != 0) ? q.pop_front() : 8'hXX;
      compares++;
      if (rdata !== e) begin
        n_mismatch++;
        $display("unexpected t=%0t got %h exp %h", $time, rdata, e);
      end
    end
    pend <= acc.rd;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(15'h0014, 8'h20);
    rd(15'h0014, 8'h00);
    rd(15'h0011, 8'h00);
    for (int i = 0; i < 6; i++) begin
      m = (i == 5) ? 8'h80 : 8'(1 << i);
      pulse(6'(1 << i));
      chk_flags(m, 8'h04);
      rd(15'h0011, m);
      rd(15'h0014, 8'h04);
      wr(15'h0011, (i == 4) ? 8'h00 : m);
      rd(15'h0011, 8'h00);
    end
    wr(15'h0011, 8'hFF);
    rd(15'h0011, 8'h10);
    wr(15'h0011, 8'h00);
    @(posedge clk);
    en_n <= 2'h3;
    strict <= 1'b0;
    pulse(6'h0A);
    rd(15'h0011, 8'h00);
    up <= xs();
    com <= 1'b1;
    clmp <= 8'h04;
    repeat (6) @(posedge clk);
    clmp <= 8'h00;
    repeat (6) @(posedge clk);
    chk_flags(8'h00, {2'b01, 2'b00, |up, 3'b010});
    rd(15'h0014, {2'b01, 2'b00, |up, 3'b010});
    rd(15'h0014, {2'b01, 2'b00, |up, 3'b000});
    wr(15'h0014, 8'hFF);
    com <= 1'b0;
    up <= '0;
    lo <= xs() | 8'h01;
    clmp <= 8'h80;
    repeat (6) @(posedge clk);
    chk_flags(8'h00, 8'h0A);
    rd(15'h0014, 8'h0A);
    rd(15'h0014, 8'h0A);
    clmp <= 8'h00;
    lo <= '0;
    repeat (6) @(posedge clk);
    chk_flags(8'h00, 8'h02);
    rd(15'h0014, 8'h02);
    rd(15'h0014, 8'h00);
    rd(15'h0012, 8'h00);
    // Frozen clock enable must swallow events; then a half-enabled checksum
    en   <= 2'h0;
    en_n <= 2'h2;
    ce   <= 1'b0;
    pulse(6'h28);
    ce   <= 1'b1;
    rd(15'h0011, 8'h00);
    pulse(6'h08);
    rd(15'h0011, 8'h00);
    // Event and write-one-clear in the same cycle: the event wins
    pulse(6'h01);
    fork
      wr(15'h0011, 8'h01);
      pulse(6'h01);
    join
    rd(15'h0011, 8'h01);
    // Second reset in mid-run clears the flags and raises the reset flag
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_flags(8'h00, 8'h20);
    rd(15'h0014, 8'h20);
    rd(15'h0011, 8'h00);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule : tb_idsf_status_flags
